// ---- verilog/dpc_pin_if.sv ----
// ddr2 command, address, clock enable and data mask pin logic
`default_nettype none
`include "dpc_regs.svh"
module dpc_pin_if #(
  parameter int DQ_W = `DPC_DQ_W,
  parameter int ROW_W = `DPC_ROW_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // command and address pins
  input wire dpc_pkg::dpc_pins_type i_pins,
  // write strobe edges with data and mask
  input wire logic i_dqs_rise,
  input wire logic i_dqs_fall,
  input wire logic [DQ_W-1:0] i_dq,
  input wire logic i_dm,
  // array answer to the read request, same cycle
  input wire logic [DQ_W-1:0] i_rd_data,
  // input buffer enables and mask pin mode
  output logic o_clk_buf_en,
  output logic o_odt_buf_en,
  output logic o_cmd_buf_en,
  output logic o_dm_is_rdqs,
  // array accesses
  output dpc_pkg::dpc_acc_type o_wr,
  output dpc_pkg::dpc_acc_type o_rd,
  // read data beats
  output logic o_dq_valid,
  output logic o_dq_phase,
  output logic [DQ_W-1:0] o_dq,
  // state seen by the core
  output dpc_pkg::dpc_pwr_type o_pwr,
  output logic [`DPC_NBANK-1:0] o_bank_open
);
  dpc_pkg::dpc_state_type st_ff;
  dpc_pkg::dpc_state_type nxt_st;
  dpc_pkg::dpc_cmd_type cmd;
  logic cmd_en;
  logic bl8;
  logic ilv;
  logic rdqs;
  logic edge_in;
  logic last;
  logic [`DPC_NBANK-1:0] ba_mask;

  // the package types fix the widths, so other values cannot be served
  if (DQ_W != `DPC_DQ_W || ROW_W != `DPC_ROW_W) begin : g_bad_width
    $error("dpc_pin_if: widths must match the package types");
  end

  function automatic logic [`DPC_COL_W-1:0] f_col(
    input logic [`DPC_COL_W-1:0] s,
    input logic [2:0] i,
    input logic b8,
    input logic il
  );
    logic [2:0] lo;
    begin
      lo = il ? (s[2:0] ^ i) : 3'(s[2:0] + i);
      if (b8) begin
        return {s[`DPC_COL_W-1:3], lo};
      end
      return {s[`DPC_COL_W-1:2], lo[1:0]};
    end
  endfunction

  // command decode on the rising crossing
  assign cmd = dpc_pkg::dpc_cmd_type'({i_pins.ras_n, i_pins.cas_n,
                                       i_pins.we_n});
  assign cmd_en = (st_ff.pwr == dpc_pkg::PWR_ON) && st_ff.cke && i_pins.cke
                  && !i_pins.cs_n;
  assign bl8 = (st_ff.mr[`DPC_MR_BURST][`DPC_BL_MSB:`DPC_BL_LSB]
                == `DPC_BL8_CODE);
  assign ilv = st_ff.mr[`DPC_MR_BURST][`DPC_BT_BIT];
  assign rdqs = st_ff.mr[`DPC_MR_EXT1][`DPC_RDQS_BIT];
  assign edge_in = i_dqs_rise || i_dqs_fall;
  assign last = (st_ff.beat == (bl8 ? `DPC_LAST8 : `DPC_LAST4));
  assign ba_mask = `DPC_NBANK'(1) << i_pins.ba;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cke = i_pins.cke;
    nxt_st.wr.valid = 1'b0;
    nxt_st.rd = '0;
    nxt_st.dout_v = st_ff.rd.valid;
    nxt_st.dout_phase = st_ff.rd_phase;
    if (st_ff.rd.valid) begin
      nxt_st.dout = i_rd_data;
    end
    // power state
    unique case (st_ff.pwr)
      dpc_pkg::PWR_ON: begin
        if (st_ff.cke && !i_pins.cke) begin
          if (!i_pins.cs_n && cmd == dpc_pkg::CMD_REF && st_ff.open == '0) begin
            nxt_st.pwr = dpc_pkg::PWR_SREF;
          end else if (st_ff.open == '0) begin
            nxt_st.pwr = dpc_pkg::PWR_PPD;
          end else begin
            nxt_st.pwr = dpc_pkg::PWR_APD;
          end
        end
      end
      dpc_pkg::PWR_PPD, dpc_pkg::PWR_APD, dpc_pkg::PWR_SREF: begin
        if (i_pins.cke) begin
          nxt_st.pwr = dpc_pkg::PWR_ON;
        end
      end
    endcase
    // burst engine
    if (st_ff.bact) begin
      if (!st_ff.bwr) begin
        nxt_st.rd.valid = 1'b1;
        nxt_st.rd.bank = st_ff.bbank;
        nxt_st.rd.row = st_ff.row[st_ff.bbank];
        nxt_st.rd.col = f_col(st_ff.bcol, st_ff.beat, bl8, ilv);
        nxt_st.rd_phase = st_ff.beat[0];
      end
      if (!st_ff.bwr || edge_in) begin
        nxt_st.beat = 3'(st_ff.beat + 3'h1);
        if (st_ff.bwr) begin
          nxt_st.wr.valid = !(i_dm && !rdqs);
          nxt_st.wr.bank = st_ff.bbank;
          nxt_st.wr.row = st_ff.row[st_ff.bbank];
          nxt_st.wr.col = f_col(st_ff.bcol, st_ff.beat, bl8, ilv);
          nxt_st.wr.data = i_dq;
        end
        if (last) begin
          nxt_st.bact = 1'b0;
          if (st_ff.bap) begin
            nxt_st.open[st_ff.bbank] = 1'b0;
          end
        end
      end
    end
    // commands
    if (cmd_en) begin
      unique case (cmd)
        dpc_pkg::CMD_MRS: begin
          if (st_ff.open == '0 && !st_ff.bact) begin
            nxt_st.mr[i_pins.ba[1:0]] = i_pins.addr;
          end
        end
        dpc_pkg::CMD_PRE: begin
          if (i_pins.addr[`DPC_AP_BIT]) begin
            nxt_st.open = '0;
          end else begin
            nxt_st.open = nxt_st.open & ~ba_mask;
          end
        end
        dpc_pkg::CMD_ACT: begin
          nxt_st.open[i_pins.ba] = 1'b1;
          nxt_st.row[i_pins.ba] = i_pins.addr;
        end
        dpc_pkg::CMD_WR, dpc_pkg::CMD_RD: begin
          if (st_ff.open[i_pins.ba] && !st_ff.bact) begin
            nxt_st.bact = 1'b1;
            nxt_st.bwr = (cmd == dpc_pkg::CMD_WR);
            nxt_st.bbank = i_pins.ba;
            nxt_st.bcol = i_pins.addr[`DPC_COL_W-1:0];
            nxt_st.bap = i_pins.addr[`DPC_AP_BIT];
            nxt_st.beat = 3'h0;
          end
        end
        dpc_pkg::CMD_REF, dpc_pkg::CMD_RSVD, dpc_pkg::CMD_NOP: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // clock buffer wakes straight from cke in self-refresh
  assign o_clk_buf_en = (st_ff.pwr != dpc_pkg::PWR_SREF) || i_pins.cke;
  assign o_odt_buf_en = (st_ff.pwr != dpc_pkg::PWR_SREF);
  assign o_cmd_buf_en = (st_ff.pwr == dpc_pkg::PWR_ON);
  assign o_dm_is_rdqs = rdqs;
  assign o_wr = st_ff.wr;
  assign o_rd = st_ff.rd;
  assign o_dq_valid = st_ff.dout_v;
  assign o_dq_phase = st_ff.dout_phase;
  assign o_dq = st_ff.dout;
  assign o_pwr = st_ff.pwr;
  assign o_bank_open = st_ff.open;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic start_rd;
  assign start_rd = cmd_en && cmd == dpc_pkg::CMD_RD && !st_ff.bact
                    && st_ff.open[i_pins.ba];

  a_cs_masks: assert property (i_pins.cs_n && !st_ff.bact |=> !st_ff.bact)
    else $error("burst started while deselected");
  a_pre_all: assert property (cmd_en && cmd == dpc_pkg::CMD_PRE
    && i_pins.addr[`DPC_AP_BIT] |=> st_ff.open == '0)
    else $error("precharge all left a bank open");
  a_pre_one: assert property (cmd_en && cmd == dpc_pkg::CMD_PRE && !st_ff.bact
    && !i_pins.addr[`DPC_AP_BIT] |=> st_ff.open == ($past(st_ff.open)
    & ~$past(ba_mask)))
    else $error("single precharge hit the wrong banks");
  a_act_row: assert property (cmd_en && cmd == dpc_pkg::CMD_ACT |=>
    st_ff.open[$past(i_pins.ba)] && st_ff.row[$past(i_pins.ba)]
    == $past(i_pins.addr))
    else $error("activate did not open the row");
  a_mrs_load: assert property (cmd_en && cmd == dpc_pkg::CMD_MRS
    && st_ff.open == '0 && !st_ff.bact |=>
    st_ff.mr[$past(i_pins.ba[1:0])] == $past(i_pins.addr))
    else $error("mode register not loaded");
  a_apd_entry: assert property (st_ff.pwr == dpc_pkg::PWR_ON && st_ff.cke
    && !i_pins.cke && st_ff.open != '0 |=> st_ff.pwr == dpc_pkg::PWR_APD)
    else $error("active power-down not entered");
  a_sref_bufs: assert property (st_ff.pwr == dpc_pkg::PWR_SREF && !i_pins.cke
    |-> !o_clk_buf_en && !o_odt_buf_en && !o_cmd_buf_en)
    else $error("buffer alive in self-refresh");
  a_pd_bufs: assert property ((st_ff.pwr == dpc_pkg::PWR_PPD
    || st_ff.pwr == dpc_pkg::PWR_APD) |-> o_clk_buf_en && o_odt_buf_en
    && !o_cmd_buf_en)
    else $error("wrong buffers in power-down");
  a_mask_drop: assert property (st_ff.bact && st_ff.bwr && edge_in && i_dm
    && !rdqs |=> !o_wr.valid)
    else $error("masked beat stored");
  a_burst_four: assert property (start_rd && !bl8 |=> ##1 o_rd.valid[*4]
    ##1 !o_rd.valid)
    else $error("read burst of four has wrong length");
  a_rdqs_keep: assert property (st_ff.bact && st_ff.bwr && edge_in && rdqs
    |=> o_wr.valid)
    else $error("beat dropped while mask pin is a strobe");

  c_read: cover property (start_rd ##2 o_rd.valid);
  c_write: cover property (st_ff.bact && st_ff.bwr && edge_in ##1 o_wr.valid);
  c_ilv: cover property (start_rd && ilv ##2 o_rd.valid);
  c_sref: cover property (st_ff.pwr == dpc_pkg::PWR_SREF ##1
    st_ff.pwr == dpc_pkg::PWR_ON);
endmodule : dpc_pin_if
`default_nettype wire

// ---- verilog/dpc_regs.svh ----
// constants for the ddr2 command and control pin interface
// Behaviour
// - sample every address and control pin on the rising clock crossing; the odt pin is never sampled
// - read beats alternate rising and falling crossing, giving double rate; here one beat per clock cycle, crossing flagged on o_dq_phase
// - cke low: idle banks give precharge power-down or self-refresh, else active
// - cke registered for power-down and self-refresh entry; self-refresh exit on the clock edge, only the clock buffer wakes async
// - power-down disables all input buffers except clock, odt and cke
// - self-refresh disables all input buffers except cke, clock ignored too
// - any command is ignored while chip select is sampled high
// - command decoded from ras, cas and we together with chip select
// - a write beat whose data mask is high is not stored
// - data mask sampled on both rising and falling data strobe edges
// - mask pin is data mask or read strobe, chosen by extended register one
// - activate, read, write, single precharge act on bank address bank
// - mode register set writes the register chosen by bank address
// - activate takes row; read or write take column and auto-precharge bit
// - precharge closes one bank with a10 low, all banks with a10 high
// - mode register set loads the op-code from the address pins
// - each access is a burst of four or eight in programmed order
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH
`define DPC_NBANK 8
`define DPC_BA_W 3
`define DPC_ROW_W 14
`define DPC_COL_W 10
`define DPC_DQ_W 8
`define DPC_NMR 4
`define DPC_AP_BIT 10
`define DPC_MR_BURST 2'h0
`define DPC_MR_EXT1 2'h1
`define DPC_BL_MSB 2
`define DPC_BL_LSB 0
`define DPC_BT_BIT 3
`define DPC_RDQS_BIT 11
`define DPC_BL8_CODE 3'h3
`define DPC_LAST4 3'h3
`define DPC_LAST8 3'h7
`define DPC_MR_RST 14'h0000
`endif

// ---- verilog/dpc_pkg.sv ----
// types of the ddr2 command and control pin interface
`default_nettype none
package dpc_pkg;
  typedef enum logic [1:0] {
    PWR_ON = 2'b00,
    PWR_PPD = 2'b01,
    PWR_APD = 2'b10,
    PWR_SREF = 2'b11
  } dpc_pwr_type;
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR = 3'b100,
    CMD_RD = 3'b101,
    CMD_RSVD = 3'b110,
    CMD_NOP = 3'b111
  } dpc_cmd_type;
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [2:0] ba;
    logic [13:0] addr;
  } dpc_pins_type;
  typedef struct packed {
    logic valid;
    logic [2:0] bank;
    logic [13:0] row;
    logic [9:0] col;
    logic [7:0] data;
  } dpc_acc_type;
  typedef struct packed {
    dpc_pwr_type pwr;
    logic cke;
    logic [7:0] open;
    logic [7:0][13:0] row;
    logic [3:0][13:0] mr;
    logic bact;
    logic bwr;
    logic bap;
    logic [2:0] bbank;
    logic [9:0] bcol;
    logic [2:0] beat;
    dpc_acc_type wr;
    dpc_acc_type rd;
    logic rd_phase;
    logic dout_v;
    logic dout_phase;
    logic [7:0] dout;
  } dpc_state_type;
endpackage : dpc_pkg
`default_nettype wire

// ---- verif/dpc_ctrl_model.sv ----
// controller side model driving the ddr2 command and address pins
`default_nettype none
module dpc_ctrl_model (
  // request from the bench
  input wire logic i_go,
  input wire logic i_cs_hi,
  input wire logic i_cke,
  input wire dpc_pkg::dpc_cmd_type i_cmd,
  input wire logic [2:0] i_ba,
  input wire logic [13:0] i_addr,
  // pins toward the device
  output dpc_pkg::dpc_pins_type o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    o_pins.cke = i_cke;
    // idle cycles deselect and invert the bus so stale values never match
    o_pins.cs_n = !i_go | i_cs_hi;
    {o_pins.ras_n, o_pins.cas_n, o_pins.we_n} = i_go ? i_cmd : 3'h7;
    o_pins.odt = 1'b0;
    o_pins.ba = i_go ? i_ba : ~i_ba;
    o_pins.addr = i_go ? i_addr : ~i_addr;
  end
endmodule // dpc_ctrl_model
`default_nettype wire

// ---- verif/ddr2_pin_command_interface_test.sv ----
// self-checking bench for the ddr2 command and control pin interface
`default_nettype none
module ddr2_pin_command_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, go, cs_hi, cke, rise, fall, dm;
  logic clk_en, odt_en, cmd_en, rdqs, dq_v, dq_ph;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [7:0] dq, rd_data, dq_o, open;
  dpc_pkg::dpc_acc_type lastw;
  dpc_pkg::dpc_cmd_type cmd;
  dpc_pkg::dpc_pins_type pins;
  dpc_pkg::dpc_acc_type wr, rd;
  dpc_pkg::dpc_pwr_type pwr;
  int fails, n_tests, nrd, nwr;
  dpc_ctrl_model ctl (.i_go(go), .i_cs_hi(cs_hi), .i_cke(cke), .i_cmd(cmd),
    .i_ba(ba), .i_addr(addr), .o_pins(pins));
  dpc_pin_if DUT (.i_clk(i_clk), .i_rst(i_rst), .i_pins(pins),
    .i_dqs_rise(rise), .i_dqs_fall(fall), .i_dq(dq), .i_dm(dm),
    .i_rd_data(rd_data), .o_clk_buf_en(clk_en), .o_odt_buf_en(odt_en),
    .o_cmd_buf_en(cmd_en), .o_dm_is_rdqs(rdqs), .o_wr(wr), .o_rd(rd),
    .o_dq_valid(dq_v), .o_dq_phase(dq_ph), .o_dq(dq_o), .o_pwr(pwr),
    .o_bank_open(open));
  assign rd_data = rd.col[7:0] ^ 8'h5A;
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (rd.valid === 1'b1) nrd++;
    if (wr.valid === 1'b1) begin
      nwr++;
      lastw = wr;
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic cmd_t(input dpc_pkg::dpc_cmd_type c, input logic [2:0] b,
    input logic [13:0] a);
    @(posedge i_clk);
    go <= 1'b1;
    cmd <= c;
    ba <= b;
    addr <= a;
    tick(1);
    go <= 1'b0;
  endtask
  task automatic t_rd(input logic [2:0] bk, input int bl, input logic [9:0] c0,
    input logic il);
    int s, k;
    logic [9:0] e;
    s = nrd;
    k = 0;
    cmd_t(dpc_pkg::CMD_ACT, bk, 14'h0123);
    cmd_t(dpc_pkg::CMD_RD, bk, {4'h0, c0});
    while (rd.valid !== 1'b1) begin
      tick(1);
      k++;
      if (k > 20) begin
        fails++;
        tally_and_finish();
      end
    end
    for (int b = 0; b < bl; b++) begin
      if (il) e = 10'(c0 ^ b);
      else e = 10'((c0 & ~(bl - 1)) | ((c0 + b) & (bl - 1)));
      chk(rd.col, e);
      chk({rd.bank, rd.row}, {bk, 14'h0123});
      tick(1);
      chk({dq_v, dq_ph, dq_o}, {1'b1, b[0], e[7:0] ^ 8'h5A});
    end
    chk(nrd - s, bl);
    chk(open[bk], 1'b1);
    $display("read burst of %0d done", bl);
  endtask
  task automatic t_wr();
    cmd_t(dpc_pkg::CMD_WR, 3'h2, 14'h0400);
    for (int b = 0; b < 4; b++) begin
      @(posedge i_clk);
      rise <= ~b[0];
      fall <= b[0];
      dq <= 8'h10 + 8'(b);
      dm <= (b == 1);
    end
    @(posedge i_clk);
    rise <= 1'b0;
    fall <= 1'b0;
    tick(3);
    chk(nwr, 3);
    chk(lastw.data, 8'h13);
    chk({lastw.bank, lastw.row, lastw.col}, {3'h2, 14'h0123, 10'h003});
    chk(open, 8'h00);
    $display("masked write done");
  endtask
  task automatic t_cs();
    cs_hi <= 1'b1;
    cmd_t(dpc_pkg::CMD_ACT, 3'h5, 14'h0010);
    cs_hi <= 1'b0;
    tick(2);
    chk(open, 8'h00);
    $display("deselect masking done");
  endtask
  task automatic t_rdqs();
    int s;
    cmd_t(dpc_pkg::CMD_MRS, 3'h1, 14'h0800);
    cmd_t(dpc_pkg::CMD_MRS, 3'h0, 14'h000B);
    chk(rdqs, 1'b1);
    t_rd(3'h4, 8, 10'h005, 1'b1);
    s = nwr;
    cmd_t(dpc_pkg::CMD_ACT, 3'h6, 14'h0042);
    cmd_t(dpc_pkg::CMD_WR, 3'h6, 14'h0400);
    for (int b = 0; b < 8; b++) begin
      @(posedge i_clk);
      rise <= ~b[0];
      fall <= b[0];
      dq <= 8'h20 + 8'(b);
      dm <= 1'b1;
    end
    @(posedge i_clk);
    rise <= 1'b0;
    fall <= 1'b0;
    dm <= 1'b0;
    tick(3);
    chk(nwr - s, 8);
    chk({lastw.bank, lastw.row, lastw.col}, {3'h6, 14'h0042, 10'h007});
    chk(lastw.data, 8'h27);
    chk(open, 8'h10);
    $display("strobe mode write and interleaved read done");
  endtask
  task automatic t_pwr();
    cmd_t(dpc_pkg::CMD_ACT, 3'h1, 14'h0001);
    cmd_t(dpc_pkg::CMD_PRE, 3'h0, 14'h0000);
    chk(open, 8'h02);
    cke <= 1'b0;
    tick(2);
    chk({pwr, cmd_en, clk_en, odt_en}, {dpc_pkg::PWR_APD, 3'b011});
    cke <= 1'b1;
    tick(2);
    chk(pwr, dpc_pkg::PWR_ON);
    cmd_t(dpc_pkg::CMD_PRE, 3'h5, 14'h0400);
    chk(open, 8'h00);
    cke <= 1'b0;
    tick(2);
    chk(pwr, dpc_pkg::PWR_PPD);
    cke <= 1'b1;
    tick(2);
    @(posedge i_clk);
    go <= 1'b1;
    cmd <= dpc_pkg::CMD_REF;
    cke <= 1'b0;
    tick(1);
    go <= 1'b0;
    tick(1);
    chk({pwr, cmd_en, clk_en, odt_en}, {dpc_pkg::PWR_SREF, 3'b000});
    cke <= 1'b1;
    #1;
    chk(clk_en, 1'b1);
    tick(2);
    chk(pwr, dpc_pkg::PWR_ON);
    $display("power states done");
  endtask
  initial begin
    {go, cs_hi, cke, rise, fall, dm, ba, addr, dq} = '0;
    cmd = dpc_pkg::CMD_NOP;
    {fails, n_tests, nrd, nwr} = '0;
    i_rst = 1'b1;
    tick(4);
    chk({pwr, open, cmd_en, clk_en, odt_en, rdqs}, {10'h000, 4'b1110});
    @(posedge i_clk);
    i_rst <= 1'b0;
    cke <= 1'b1;
    tick(1);
    t_cs();
    t_rd(3'h2, 4, 10'h006, 1'b0);
    t_wr();
    cmd_t(dpc_pkg::CMD_MRS, 3'h0, 14'h0003);
    t_rd(3'h0, 8, 10'h005, 1'b0);
    t_pwr();
    t_rdqs();
    tally_and_finish();
  end
endmodule // ddr2_pin_command_interface_test
`default_nettype wire
